// *** rtl/dar_defs.vh ***
// Register map, field positions and reset values of the result register bank
`ifndef DAR_DEFS_VH
`define DAR_DEFS_VH

// Register indices; the byte address is four times the index
`define DAR_IDX_CONTROL 10'h000
`define DAR_IDX_DIAG_TWO 10'h058
`define DAR_IDX_SIDE_ZERO 10'h059
`define DAR_IDX_SIDE_ONE 10'h05a
`define DAR_IDX_SIDE_TWO 10'h05b

// Control register fields
`define DAR_CTL_MEAS_EN 0
`define DAR_CTL_ANALOG_LO 1
`define DAR_CTL_ANALOG_HI 3
`define DAR_CTL_RATIO 4
`define DAR_CTL_WIDTH 5
`define DAR_CTL_RESET 5'h00

// Result field inside a 16-bit result register
`define DAR_RES_LO 2
`define DAR_RES_HI 15
`define DAR_RES_RESET 14'h0000
`define DAR_SIDE_COUNT 3

// AXI response codes
`define DAR_RESP_OKAY 2'h0
`define DAR_RESP_DECERR 2'h3

`endif

// *** rtl/dar_result_bank.v ***
// Diagnostic and auxiliary result registers behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "dar_defs.vh"

module dar_result_bank #(
    parameter ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // AXI4-Lite write address
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Measurement engine results
    input wire secondCheckDone,
    input wire [13:0] secondCheckValue,
    input wire sideInputDone,
    input wire [1:0] sideInputChannel,
    input wire [13:0] sideInputValueN,
    // Settings toward the measurement engine
    output wire sideInputMeasureEnable,
    output wire [2:0] sidePortAnalog,
    output wire ratiometricMode
);

    function [9:0] regIndex;
        input [ADDR_WIDTH-1:0] addr;
        begin
            regIndex = addr[11:2];
        end
    endfunction

    function isMapped;
        input [9:0] idx;
        begin
            isMapped = (idx == `DAR_IDX_CONTROL) || (idx == `DAR_IDX_DIAG_TWO) ||
                (idx == `DAR_IDX_SIDE_ZERO) || (idx == `DAR_IDX_SIDE_ONE) ||
                (idx == `DAR_IDX_SIDE_TWO);
        end
    endfunction

    // Aux word as software sees it; a non-analog port reads zero, stored value waits
    function [15:0] sideWord;
        input analog;
        input [13:0] value;
        begin
            sideWord = analog ? {value, 2'b00} : 16'h0000;
        end
    endfunction

    // One aux slot takes the engine result only when enabled and set analog
    function sideHit;
        input take;
        input [1:0] channel;
        input [1:0] slot;
        input analog;
        begin
            sideHit = take && (channel == slot) && analog;
        end
    endfunction

    reg [`DAR_CTL_WIDTH-1:0] control_q;
    reg [13:0] secondCheckValue_q;
    reg [13:0] sideInputValue0_q;
    reg [13:0] sideInputValue1_q;
    reg [13:0] sideInputValue2_q;

    reg awHeld_q;
    reg wHeld_q;
    reg [ADDR_WIDTH-1:0] awAddr_q;
    reg [31:0] wData_q;
    reg wStrb0_q;
    reg bValid_q;
    reg [1:0] bResp_q;
    reg rValid_q;
    reg [31:0] rData_q;
    reg [1:0] rResp_q;

    wire [9:0] wrIdx = regIndex(awAddr_q);
    wire wrFire = awHeld_q && wHeld_q && !bValid_q;

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    assign sideInputMeasureEnable = control_q[`DAR_CTL_MEAS_EN];
    assign sidePortAnalog = control_q[`DAR_CTL_ANALOG_HI:`DAR_CTL_ANALOG_LO];
    // Engine picks supply or reference as full scale from this bit
    // scale reference select
    assign ratiometricMode = control_q[`DAR_CTL_RATIO];

    // Write channel: address and data are taken in either order
    always @(posedge ref_clk) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= {ADDR_WIDTH{1'b0}};
            wData_q <= 32'h00000000;
            wStrb0_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= `DAR_RESP_OKAY;
            control_q <= `DAR_CTL_RESET;
        end else begin
            if (s_axi_awvalid && !awHeld_q) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld_q) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb0_q <= s_axi_wstrb[0];
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= isMapped(wrIdx) ? `DAR_RESP_OKAY : `DAR_RESP_DECERR;
                // Result registers ignore writes; only control takes data
                // results read-only
                if (wrIdx == `DAR_IDX_CONTROL && wStrb0_q) begin
                    control_q <= wData_q[`DAR_CTL_WIDTH-1:0];
                end
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    // Read mux; masking at read keeps the stored value for when the port turns analog
    reg [15:0] rdWord;
    reg rdHit;
    always @* begin
        rdWord = 16'h0000;
        rdHit = 1'b1;
        case (regIndex(s_axi_araddr))
            `DAR_IDX_CONTROL: rdWord = {11'h000, control_q};
            `DAR_IDX_DIAG_TWO: rdWord = {secondCheckValue_q, 2'b00};
            `DAR_IDX_SIDE_ZERO: rdWord = sideWord(sidePortAnalog[0], sideInputValue0_q);
            `DAR_IDX_SIDE_ONE: rdWord = sideWord(sidePortAnalog[1], sideInputValue1_q);
            `DAR_IDX_SIDE_TWO: rdWord = sideWord(sidePortAnalog[2], sideInputValue2_q);
            default: rdHit = 1'b0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= `DAR_RESP_OKAY;
        end else if (s_axi_arvalid && !rValid_q) begin
            rValid_q <= 1'b1;
            // upper half zero; low two bits zero except on control reads
            rData_q <= {16'h0000, rdWord};
            rResp_q <= rdHit ? `DAR_RESP_OKAY : `DAR_RESP_DECERR;
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    // Result capture from the measurement engine
    wire sideTake = sideInputDone && sideInputMeasureEnable;
    always @(posedge ref_clk) begin
        if (rst) begin
            secondCheckValue_q <= `DAR_RES_RESET;
            sideInputValue0_q <= `DAR_RES_RESET;
            sideInputValue1_q <= `DAR_RES_RESET;
            sideInputValue2_q <= `DAR_RES_RESET;
        end else begin
            if (secondCheckDone) begin
                secondCheckValue_q <= secondCheckValue;
            end
            // A skipped channel sees no take, so its old value remains
            // hold when skipped
            if (sideHit(sideTake, sideInputChannel, 2'd0, sidePortAnalog[0])) begin
                sideInputValue0_q <= sideInputValueN;
            end
            if (sideHit(sideTake, sideInputChannel, 2'd1, sidePortAnalog[1])) begin
                sideInputValue1_q <= sideInputValueN;
            end
            if (sideHit(sideTake, sideInputChannel, 2'd2, sidePortAnalog[2])) begin
                sideInputValue2_q <= sideInputValueN;
            end
        end
    end

endmodule

// *** verification/dar_result_bank_properties.sv ***
// Port assertions for the result register bank
`timescale 1ns/10ps
module dar_result_bank_properties #(
    parameter ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Read channel
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Write response
    input wire s_axi_bvalid,
    // Engine settings
    input wire sideInputMeasureEnable,
    input wire [2:0] sidePortAnalog,
    input wire ratiometricMode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // Result and unmapped reads only; control keeps live bits at 1:0
    chk_low_bits: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[11:2] != 10'h000 |=> s_axi_rdata[1:0] == 2'h0)
        else $error("unused low bits set");
    chk_ratio_stable: assert property (
        !$rose(s_axi_bvalid) |-> $stable(ratiometricMode))
        else $error("scaling mode moved without write");
    chk_enable_stable: assert property (
        !$rose(s_axi_bvalid) |-> $stable(sideInputMeasureEnable))
        else $error("enable moved without write");
    chk_analog_stable: assert property (
        !$rose(s_axi_bvalid) |-> $stable(sidePortAnalog))
        else $error("port config moved without write");
    chk_reset_clear: assert property (
        $past(rst) |-> !s_axi_rvalid && sidePortAnalog == 3'h0)
        else $error("state not cleared by reset");
endmodule
bind dar_result_bank dar_result_bank_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.ref_clk, .rst,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bvalid, .sideInputMeasureEnable, .sidePortAnalog, .ratiometricMode);

// *** verification/testbench.sv ***
// Self-checking bench for the result register bank
`timescale 1ns/10ps
module testbench;
    logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, secondCheckDone;
    logic sideInputDone, sideInputMeasureEnable, ratiometricMode;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, sideInputChannel;
    logic [13:0] secondCheckValue, sideInputValueN;
    logic [2:0] sidePortAnalog;
    integer miscompares = 0;
    integer n_tests = 0;
    integer cyc = 0;
    dar_result_bank dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .secondCheckDone, .secondCheckValue, .sideInputDone,
        .sideInputChannel, .sideInputValueN, .sideInputMeasureEnable, .sidePortAnalog,
        .ratiometricMode);
    task automatic print_verdict;
        $display("counts: %0d compares, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Address and data are released separately, as each is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        n_tests++;
        if (s_axi_bresp !== r) begin
            miscompares++;
            $display("mismatch bresp %h exp %h got %h", a, r, s_axi_bresp);
        end
        // Idle edge so the next call never redrives these in the same time step
        @(posedge ref_clk);
    endtask
    // Expected value carries the response code above the data word
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        n_tests++;
        if ({s_axi_rresp, s_axi_rdata} !== e) begin
            miscompares++;
            $display("mismatch reg %h exp %h got %h", a, e, {s_axi_rresp, s_axi_rdata});
        end
        @(posedge ref_clk);
    endtask
    task automatic cfg(input logic [4:0] d);
        wr(12'h000, {27'h0, d}, 2'h0);
        n_tests++;
        if ({ratiometricMode, sidePortAnalog, sideInputMeasureEnable} !== d) begin
            miscompares++;
            $display("mismatch settings exp %h got %h", d,
                {ratiometricMode, sidePortAnalog, sideInputMeasureEnable});
        end
    endtask
    task automatic eng(input logic d, input logic [1:0] c, input logic [13:0] v);
        secondCheckDone <= d;
        sideInputDone <= !d;
        sideInputChannel <= c;
        secondCheckValue <= v;
        sideInputValueN <= v;
        @(posedge ref_clk);
        secondCheckDone <= 1'b0;
        sideInputDone <= 1'b0;
        @(posedge ref_clk);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        rst <= 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {secondCheckDone, sideInputDone, sideInputChannel} <= 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, secondCheckValue, sideInputValueN} <= 'h0;
        s_axi_wstrb <= 4'hf;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 5; i++) rd(12'h15c + 12'(4 * i) & {12{i != 0}}, 34'h0);
        $display("test reset values done");
        cfg(5'h0f);
        eng(1'b1, 2'h0, 14'h2aaa);
        eng(1'b1, 2'h0, 14'h3abc);
        rd(12'h160, 34'h0eaf0);
        for (int i = 0; i < 3; i++) eng(1'b0, 2'(i), 14'h1230 + 14'(i));
        for (int i = 0; i < 3; i++) rd(12'h164 + 12'(4 * i), 34'(4 * (32'h1230 + i)));
        $display("test result update done");
        wr(12'h164, 32'hffffffff, 2'h0);
        cfg(5'h0e);
        eng(1'b0, 2'h0, 14'h0555);
        rd(12'h164, 34'h48c0);
        cfg(5'h1b);
        eng(1'b0, 2'h1, 14'h0777);
        rd(12'h168, 34'h0);
        cfg(5'h0f);
        rd(12'h168, 34'h48c4);
        wr(12'h200, 32'h0000001b, 2'h3);
        rd(12'h000, 34'h0f);
        rd(12'h200, 34'h300000000);
        $display("test hold and config done");
        print_verdict;
    end
endmodule
